// file: core/ccs_ctrl.v
// clock switchover and sleep control register with its sleep state machine
`timescale 1ns/10ps
`default_nettype none
`include "ccs_map.vh"

// Notes on behaviour
// - bit 7 picks metering clock source, reads back
// - pll start write starts pll, selects it
// - accepted pll start locks; zero unlocks only
// - force sleep: processor on oscillator, pll off, stop
// - force sleep sleeps only on battery, never deep
// - bits 4,3 stop metering, lcd clocks
// - lcd gate acts only with both pll selects
// - battery, osc processor: 01/11 enters sleep
// - same preconditions: 10 enters deep sleep
// - bit 0 picks processor clock source, reads back
// - non-resetting wakeup resumes with state kept
// - such wakeup clears bits 6,5,2,1 only
// - line power indicator high above sense threshold
// - deep sleep exits on io or power recovery
module ccs_ctrl
(
  // clock and reset
  input  wire       mclk,
  input  wire       rstn,
  // special-function-register port
  input  wire [7:0] sfr_addr,
  input  wire [7:0] sfr_wdata,
  input  wire       sfr_we,
  input  wire       sfr_re,
  output reg  [7:0] sfr_rdata,
  // asynchronous inputs from pins and analog blocks
  input  wire       supply_sense_input,
  input  wire       wake_io,
  input  wire       wake_rtc_cf,
  // wakeup configuration, same clock domain
  input  wire       wakeup_without_reset,
  // clock source selects and pll control
  output wire       processor_clock_select,
  output wire       metering_clock_select,
  output wire       pll_enable,
  output wire       clock_lock,
  // clock enables
  output wire       processor_clock_enable,
  output wire       auxiliary_clock_enable,
  output wire       metering_clock_enable,
  output wire       lcd_clock_enable,
  // power and sleep status
  output wire       line_power_indicator,
  output wire       sleep_active,
  output wire       deep_sleep_active,
  output reg        wake_reset_req
);

  // ----------------------------------------------------------------
  // state encoding
  // ----------------------------------------------------------------
  localparam [2:0] ST_AWAKE = 3'b001;  // processor running
  localparam [2:0] ST_SLEEP = 3'b010;  // sleep
  localparam [2:0] ST_DEEP  = 3'b100;  // deep sleep

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  reg  [7:0] ctrl;            // clock_switch_control contents
  reg  [7:0] next_ctrl;       // next register value
  reg        pll_run;         // pll oscillator running
  reg        next_pll_run;    // next pll state
  reg  [2:0] state;           // sleep state machine
  reg  [2:0] next_state;      // next sleep state
  reg        accept_start;    // pll start write honoured
  reg        go_sleep;        // entry into sleep this cycle
  reg        go_deep;         // entry into deep sleep this cycle
  reg        wake_fire;       // a valid wake event this cycle
  wire       ctrl_write;      // write to our address
  wire [2:0] sync_lvl;        // synchronised async inputs
  wire [2:0] rise;            // rising edges of those inputs
  wire       power_restore;   // line power came back
  wire [1:0] slp_field;       // sleep field being written
  wire       battery;         // running from battery

  // ----------------------------------------------------------------
  // input synchronisation and edge detection
  // ----------------------------------------------------------------
  ccs_sync
  #(
    .WIDTH (3)
  )
  u_sync
  (
    .mclk     (mclk),
    .rstn     (rstn),
    .async_in ({wake_rtc_cf, wake_io, supply_sense_input}),
    .sync_out (sync_lvl)
  );

  ccs_edge
  #(
    .WIDTH (3)
  )
  u_edge
  (
    .mclk       (mclk),
    .rstn       (rstn),
    .level_in   (sync_lvl),
    .rise_pulse (rise)
  );

  // comparator output high means line supply above threshold
  assign line_power_indicator = sync_lvl[0];
  assign battery              = ~sync_lvl[0];
  assign power_restore        = rise[0];

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  assign ctrl_write = sfr_we & (sfr_addr == `CCS_CTRL_ADDR);
  assign slp_field  = sfr_wdata[`CCS_SLP_HI_BIT:`CCS_SLP_LO_BIT];

  // ----------------------------------------------------------------
  // wake qualification per sleep state
  // ----------------------------------------------------------------
  always @*
  begin
    wake_fire = 1'b0;
    case (state)
      ST_SLEEP:
        // any source ends light sleep
        wake_fire = rise[1] | rise[2] | power_restore;
      ST_DEEP:
        // only io or power recovery ends deep sleep
        wake_fire = rise[1] | power_restore;
      ST_AWAKE:
        wake_fire = 1'b0;
      default:
        wake_fire = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // next register value
  // ----------------------------------------------------------------
  always @*
  begin
    next_ctrl    = ctrl;
    next_pll_run = pll_run;
    accept_start = 1'b0;
    if (wake_fire)
    begin
      if (wakeup_without_reset)
      begin
        // keep everything but the sleep and start bits
        next_ctrl[`CCS_PLL_START_BIT] = 1'b0;
        next_ctrl[`CCS_FORCE_SLP_BIT] = 1'b0;
        next_ctrl[`CCS_SLP_HI_BIT]    = 1'b0;
        next_ctrl[`CCS_SLP_LO_BIT]    = 1'b0;
      end
      else
      begin
        // default wake returns to the oscillator state
        next_ctrl    = `CCS_CTRL_RESET;
        next_pll_run = 1'b0;
      end
    end
    else if (ctrl_write)
    begin
      // source selects move only while unlocked
      if (!ctrl[`CCS_PLL_START_BIT])
      begin
        next_ctrl[`CCS_METER_SEL_BIT] = sfr_wdata[`CCS_METER_SEL_BIT];
        next_ctrl[`CCS_PROC_SEL_BIT]  = sfr_wdata[`CCS_PROC_SEL_BIT];
        if (sfr_wdata[`CCS_METER_SEL_BIT] | sfr_wdata[`CCS_PROC_SEL_BIT])
          next_pll_run = 1'b1;
      end
      // clock gates store freely
      next_ctrl[`CCS_METER_GATE_BIT] = sfr_wdata[`CCS_METER_GATE_BIT];
      next_ctrl[`CCS_LCD_GATE_BIT]   = sfr_wdata[`CCS_LCD_GATE_BIT];
      // sleep field always stores; entry is decided below
      next_ctrl[`CCS_SLP_HI_BIT] = sfr_wdata[`CCS_SLP_HI_BIT];
      next_ctrl[`CCS_SLP_LO_BIT] = sfr_wdata[`CCS_SLP_LO_BIT];
      // pll start honoured only with force sleep clear
      accept_start = ~ctrl[`CCS_FORCE_SLP_BIT] & ~sfr_wdata[`CCS_FORCE_SLP_BIT];
      if (accept_start)
      begin
        next_ctrl[`CCS_PLL_START_BIT] = sfr_wdata[`CCS_PLL_START_BIT];
        if (sfr_wdata[`CCS_PLL_START_BIT])
        begin
          // start pll and hand it the processor clock
          next_pll_run                 = 1'b1;
          next_ctrl[`CCS_PROC_SEL_BIT] = 1'b1;
        end
      end
      // force sleep overrides processor source and pll
      next_ctrl[`CCS_FORCE_SLP_BIT] = sfr_wdata[`CCS_FORCE_SLP_BIT];
      if (sfr_wdata[`CCS_FORCE_SLP_BIT])
      begin
        next_ctrl[`CCS_PROC_SEL_BIT]  = 1'b0;
        next_ctrl[`CCS_PLL_START_BIT] = 1'b0;
        next_pll_run                  = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // sleep entry decision
  // ----------------------------------------------------------------
  always @*
  begin
    go_sleep = 1'b0;
    go_deep  = 1'b0;
    if (ctrl_write && !wake_fire && battery)
    begin
      if (sfr_wdata[`CCS_FORCE_SLP_BIT])
        go_sleep = 1'b1;
      else if (!ctrl[`CCS_PROC_SEL_BIT] && !next_ctrl[`CCS_PROC_SEL_BIT])
      begin
        // processor already on oscillator; field picks depth
        case (slp_field)
          `CCS_SLP_LIGHT_A: go_sleep = 1'b1;
          `CCS_SLP_LIGHT_B: go_sleep = 1'b1;
          `CCS_SLP_DEEP:    go_deep  = 1'b1;
          `CCS_SLP_AWAKE:   go_sleep = 1'b0;
          default:          go_sleep = 1'b0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // sleep state machine
  // ----------------------------------------------------------------
  always @*
  begin
    next_state = state;
    case (state)
      ST_AWAKE:
        if (go_deep)
          next_state = ST_DEEP;
        else if (go_sleep)
          next_state = ST_SLEEP;
      ST_SLEEP:
        if (wake_fire)
          next_state = ST_AWAKE;
      ST_DEEP:
        if (wake_fire)
          next_state = ST_AWAKE;
      default:
        next_state = ST_AWAKE;
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl           <= `CCS_CTRL_RESET;
      pll_run        <= 1'b0;
      state          <= ST_AWAKE;
      wake_reset_req <= 1'b0;
    end
    else
    begin
      ctrl           <= next_ctrl;
      pll_run        <= next_pll_run;
      state          <= next_state;
      // pulse to reset the rest of the system on a default wake
      wake_reset_req <= wake_fire & ~wakeup_without_reset;
    end
  end

  // ----------------------------------------------------------------
  // read port, registered data
  // ----------------------------------------------------------------
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      sfr_rdata <= `CCS_UNMAPPED_READ;
    else if (sfr_re)
    begin
      if (sfr_addr == `CCS_CTRL_ADDR)
        sfr_rdata <= ctrl;
      else
        sfr_rdata <= `CCS_UNMAPPED_READ;
    end
  end

  // ----------------------------------------------------------------
  // clock outputs
  // ----------------------------------------------------------------
  assign processor_clock_select = ctrl[`CCS_PROC_SEL_BIT];
  assign metering_clock_select  = ctrl[`CCS_METER_SEL_BIT];
  assign pll_enable             = pll_run;
  assign clock_lock             = ctrl[`CCS_PLL_START_BIT];

  // processor and auxiliary clocks stop in either sleep state
  assign processor_clock_enable = (state == ST_AWAKE);
  assign auxiliary_clock_enable = (state == ST_AWAKE);

  // metering clock gate acts at once
  assign metering_clock_enable = ~ctrl[`CCS_METER_GATE_BIT];

  // lcd gate needs pll on both processor and metering clocks
  assign lcd_clock_enable = ~(ctrl[`CCS_LCD_GATE_BIT]
                              & ctrl[`CCS_PROC_SEL_BIT]
                              & ctrl[`CCS_METER_SEL_BIT]);

  // state flags
  assign sleep_active      = (state == ST_SLEEP);
  assign deep_sleep_active = (state == ST_DEEP);

endmodule // ccs_ctrl

`default_nettype wire

// file: core/ccs_map.vh
// register map and field layout of the clock switchover and sleep control block
`ifndef CCS_MAP_VH
`define CCS_MAP_VH

// ----------------------------------------------------------------
// register address in the special-function-register space
// ----------------------------------------------------------------
`define CCS_CTRL_ADDR      8'h80

// ----------------------------------------------------------------
// field positions of clock_switch_control
// ----------------------------------------------------------------
`define CCS_METER_SEL_BIT  7
`define CCS_PLL_START_BIT  6
`define CCS_FORCE_SLP_BIT  5
`define CCS_METER_GATE_BIT 4
`define CCS_LCD_GATE_BIT   3
`define CCS_SLP_HI_BIT     2
`define CCS_SLP_LO_BIT     1
`define CCS_PROC_SEL_BIT   0

// ----------------------------------------------------------------
// reset value and sleep field codes
// ----------------------------------------------------------------
`define CCS_CTRL_RESET     8'h00
`define CCS_SLP_AWAKE      2'h0
`define CCS_SLP_LIGHT_A    2'h1
`define CCS_SLP_DEEP       2'h2
`define CCS_SLP_LIGHT_B    2'h3
`define CCS_UNMAPPED_READ  8'h00

`endif

// file: core/ccs_sync.v
// two-flop synchroniser for asynchronous level inputs
`timescale 1ns/10ps
`default_nettype none

module ccs_sync
#(
  parameter WIDTH = 1
)
(
  // clock and reset
  input  wire             mclk,
  input  wire             rstn,
  // asynchronous level in, synchronised level out
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage_a;  // first stage, read only by stage_b
  reg [WIDTH-1:0] stage_b;  // second stage, safe to use

  // ----------------------------------------------------------------
  // two flip-flops per bit
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1)
    begin : g_bit
      always @(posedge mclk or negedge rstn)
      begin
        if (!rstn)
        begin
          stage_a[gi] <= 1'b0;
          stage_b[gi] <= 1'b0;
        end
        else
        begin
          stage_a[gi] <= async_in[gi];
          stage_b[gi] <= stage_a[gi];
        end
      end
    end
  endgenerate

  assign sync_out = stage_b;

endmodule // ccs_sync

`default_nettype wire

// file: core/ccs_edge.v
// rising-edge pulse detector on synchronised levels
`timescale 1ns/10ps
`default_nettype none

module ccs_edge
#(
  parameter WIDTH = 1
)
(
  // clock and reset
  input  wire             mclk,
  input  wire             rstn,
  // level in, one-cycle pulse out on each rise
  input  wire [WIDTH-1:0] level_in,
  output wire [WIDTH-1:0] rise_pulse
);

  reg [WIDTH-1:0] level_d;  // previous level

  // ----------------------------------------------------------------
  // delay each bit by one cycle and compare
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1)
    begin : g_bit
      always @(posedge mclk or negedge rstn)
      begin
        if (!rstn)
          level_d[gi] <= 1'b0;
        else
          level_d[gi] <= level_in[gi];
      end
      assign rise_pulse[gi] = level_in[gi] & ~level_d[gi];
    end
  endgenerate

endmodule // ccs_edge

`default_nettype wire

// file: test/ccs_ctrl_asserts.sv
// concurrent checks on the clock switchover and sleep control ports
`timescale 1ns/10ps
`default_nettype none
`include "ccs_map.vh"

module ccs_ctrl_asserts
(
  // clock and reset
  input wire logic       mclk,
  input wire logic       rstn,
  // register write port
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic       sfr_we,
  // selects, enables and sleep status
  input wire logic       processor_clock_select,
  input wire logic       metering_clock_select,
  input wire logic       pll_enable,
  input wire logic       clock_lock,
  input wire logic       processor_clock_enable,
  input wire logic       auxiliary_clock_enable,
  input wire logic       metering_clock_enable,
  input wire logic       lcd_clock_enable,
  input wire logic       line_power_indicator,
  input wire logic       sleep_active,
  input wire logic       deep_sleep_active
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // mapped write, and a battery write with the oscillator kept
  wire logic wr;
  wire logic bat;
  assign wr  = sfr_we && (sfr_addr == `CCS_CTRL_ADDR);
  // a pll start write hands the processor clock to the pll, so it cannot sleep
  assign bat = wr && !line_power_indicator && !sfr_wdata[5] && !sfr_wdata[0]
               && !sfr_wdata[6] && !processor_clock_select;

  property p_lcd_gate;
    !lcd_clock_enable |-> processor_clock_select && metering_clock_select;
  endproperty
  a_lcd_gate: assert property (p_lcd_gate) else $error("lcd stopped off pll");
  property p_meter_gate;
    wr |=> metering_clock_enable == !$past(sfr_wdata[4]);
  endproperty
  a_meter_gate: assert property (p_meter_gate) else $error("metering gate wrong");
  property p_force_src;
    wr && sfr_wdata[5] |=> !processor_clock_select && !pll_enable && !clock_lock;
  endproperty
  a_force_src: assert property (p_force_src) else $error("force sleep source");
  property p_force_bat;
    wr && sfr_wdata[5] && !line_power_indicator
      |=> sleep_active && !deep_sleep_active && !processor_clock_enable;
  endproperty
  a_force_bat: assert property (p_force_bat) else $error("force sleep state");
  property p_line_awake;
    wr && line_power_indicator |=> !sleep_active && !deep_sleep_active;
  endproperty
  a_line_awake: assert property (p_line_awake) else $error("slept on line power");
  property p_deep;
    bat && sfr_wdata[2:1] == 2'h2 |=> deep_sleep_active && !auxiliary_clock_enable;
  endproperty
  a_deep: assert property (p_deep) else $error("deep sleep not entered");
  property p_sleep;
    bat && sfr_wdata[1] |=> sleep_active && !deep_sleep_active && !auxiliary_clock_enable;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not entered");
  property p_lock_hold;
    wr && clock_lock && !sfr_wdata[5]
      |=> $stable(processor_clock_select) && $stable(metering_clock_select);
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("locked select moved");
endmodule // ccs_ctrl_asserts

bind ccs_ctrl ccs_ctrl_asserts i_chk (.mclk, .rstn, .sfr_addr, .sfr_wdata, .sfr_we,
  .processor_clock_select, .metering_clock_select, .pll_enable, .clock_lock,
  .processor_clock_enable, .auxiliary_clock_enable, .metering_clock_enable,
  .lcd_clock_enable, .line_power_indicator, .sleep_active, .deep_sleep_active);
`default_nettype wire

// file: test/test_clock_switch_sleep_control.sv
// self-checking bench for the clock switchover and sleep control block
`timescale 1ns/10ps
`default_nettype none
`define CCS_CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin miscompares++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, s); end end

module test_clock_switch_sleep_control;
  // stimulus
  logic       mclk = 0, rstn = 0, we = 0, re = 0, sup = 0, wio = 0, rtc = 0, wwr = 0;
  logic [7:0] addr = 0, wdata = 0;
  // design outputs
  wire  [7:0] rdata;
  wire        psel, msel, pll, lock, pen, aen, men, len, lpi, slp, dsl, wrr;
  // model state and scratch
  logic [7:0] m, n, r, d;
  logic       p, saw, s, dp;
  int         miscompares = 0, n_compared = 0, seed = 32'hdf85, i, k;
  logic [7:0] tbl [6] = '{8'h02, 8'h96, 8'h84, 8'h04, 8'h20, 8'h00};

  always #5 mclk = ~mclk;

  ccs_ctrl i_dut (.mclk(mclk), .rstn(rstn), .sfr_addr(addr), .sfr_wdata(wdata),
    .sfr_we(we), .sfr_re(re), .sfr_rdata(rdata), .supply_sense_input(sup),
    .wake_io(wio), .wake_rtc_cf(rtc), .wakeup_without_reset(wwr),
    .processor_clock_select(psel), .metering_clock_select(msel), .pll_enable(pll),
    .clock_lock(lock), .processor_clock_enable(pen), .auxiliary_clock_enable(aen),
    .metering_clock_enable(men), .lcd_clock_enable(len), .line_power_indicator(lpi),
    .sleep_active(slp), .deep_sleep_active(dsl), .wake_reset_req(wrr));

  // drive just after the rising edge
  task tick;
    @(posedge mclk);
    #1;
  endtask
  task rd(input logic [7:0] a);
    addr = a;
    re = 1;
    tick;
    re = 0;
    r = rdata;
  endtask
  // compare register image, both selects, lock, pll and the metering and lcd enables with the model
  task check_all;
    rd(8'h80);
    `CCS_CHK("ctrl", m, r)
    `CCS_CHK("proc_sel", m[0], psel)
    `CCS_CHK("meter_sel", m[7], msel)
    `CCS_CHK("lock", m[6], lock)
    `CCS_CHK("pll", p, pll)
    `CCS_CHK("meter_en", ~m[4], men)
    `CCS_CHK("lcd_en", ~(m[3] & m[0] & m[7]), len)
  endtask
  // model a register write, then perform it
  task put(input logic [7:0] v);
    n = v;
    if (m[6])
    begin
      n[7] = m[7];
      n[0] = m[0];
    end
    if (v[5])
    begin
      n[6] = 0;
      n[0] = 0;
      p = 0;
    end
    else if (m[5])
      n[6] = m[6];
    if (!v[5] && !m[5] && v[6])
      n[0] = 1;
    if (!v[5] && (n[0] || n[7]))
      p = 1;
    m = n;
    addr = 8'h80;
    wdata = v;
    we = 1;
    tick;
    we = 0;
    check_all;
  endtask

  task results;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    repeat (8) tick;
    rstn = 1;
    m = 8'h00;
    p = 0;
    check_all;
    // unmapped place: reads zero, write ignored
    addr = 8'h33;
    wdata = 8'hff;
    we = 1;
    tick;
    we = 0;
    rd(8'h33);
    `CCS_CHK("unmapped", 8'h00, r)
    // let an edge pass so the read strobe is not raised again in this step
    tick;
    check_all;
    // line power: no sleep from any write
    sup = 1;
    repeat (3) tick;
    `CCS_CHK("line_power", 1'b1, lpi)
    put(8'h40);
    put(8'h81);
    put(8'h00);
    put(8'h89);
    put(8'h08);
    put(8'h10);
    put(8'h20);
    `CCS_CHK("slp_line", 1'b0, slp)
    for (i = 0; i < 24; i++)
    begin
      put($random(seed));
      `CCS_CHK("awake_line", 2'b00, {slp, dsl})
    end
    // battery: each sleep code, then wake with and without reset
    // first write may only release a lock; second clears both selects
    put(8'h00);
    put(8'h00);
    sup = 0;
    repeat (3) tick;
    `CCS_CHK("battery", 1'b0, lpi)
    for (i = 0; i < 6; i++)
    begin
      d = tbl[i];
      wwr = i[0];
      s = d[5] | d[1];
      dp = !d[5] && d[2:1] == 2'h2;
      put(d);
      `CCS_CHK("sleep", s, slp)
      `CCS_CHK("deep", dp, dsl)
      `CCS_CHK("clk_en", {2{~(s | dp)}}, {pen, aen})
      if (dp)
      begin
        rtc = 1;
        repeat (6) tick;
        rtc = 0;
        `CCS_CHK("deep_rtc", 1'b1, dsl)
      end
      if (s | dp)
      begin
        // deep: io wake; force sleep: power recovery; light sleep: rtc wake
        if (dp)
          wio = 1;
        else if (i == 4)
          sup = 1;
        else
          rtc = 1;
        saw = 0;
        k = 0;
        while ((slp === 1'b1 || dsl === 1'b1) && k < 12)
        begin
          tick;
          k++;
          if (wrr === 1'b1)
            saw = 1;
        end
        if (k == 12)
        begin
          miscompares++;
          results;
        end
        wio = 0;
        rtc = 0;
        sup = 0;
        repeat (4) tick;
        `CCS_CHK("wake_rst", ~wwr, saw)
        if (wwr)
          m = m & 8'h99;
        else
        begin
          m = 8'h00;
          p = 0;
        end
        check_all;
      end
    end
    results;
  end
endmodule // test_clock_switch_sleep_control
`default_nettype wire
